// ==== hw/dcs_top.sv ====
// Functional notes
// - comparator A checks address and 32-bit data; B and D check address only.
// - each comparator watches opcode addresses or data access addresses.
// - inside range matches when low bound <= address <= high bound.
// - outside range matches when address < low or address > high.
// - access enable 0 ignores direction; else select 0 writes, 1 reads.
// - opcode select ignores access enable and direction select.
// - comparator B holds a 24-bit address compared bit for bit.
// - comparator B address readable always, writable only while disarmed.
// - data access match when address, and optionally data, equals comparator.
// - opcode match when tagged opcode reaches execution stage, before executing.
// - comparator A data match supports bit masking and direction qualification.
// - comparator match moves sequencer to configured next state.
// - sequencer may move in any direction among states 1, 2, 3.
// - final state raises breakpoint, returns to state 0, disarms.
// - external event or force trigger write also forces a transition.
// - opcode select set matches opcodes; clear matches memory accesses.
// - match 0, 1, 3 map to A, B, D except in range modes.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcs_top
  import dcs_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [AW-1:0] data_addr,
  input wire logic [DW-1:0] data_bus,
  input wire logic data_valid,
  input wire logic data_read,
  input wire logic [AW-1:0] exec_addr,
  input wire logic exec_valid,
  input wire logic ext_event,
  output logic breakpoint,
  output logic armed,
  output logic irq
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic arm_ff;
  logic [3:0] cmp_ctl_ff [3];
  logic [AW-1:0] cmp_addr_ff [3];
  logic [DW-1:0] a_data_ff;
  logic [DW-1:0] a_mask_ff;
  logic [2:0] range_ff;
  logic [23:0] trans_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic brk_ff;
  dcs_state_type state_ff;
  logic [2:0] match;
  logic [3:0] match_vec;
  logic force_trigger_wr;
  logic wr_hit;
  logic brk_evt;
  logic any_match;

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign force_trigger_wr = wr_hit && wb_adr_i == CTRL_OFS && wb_sel_i[0] && wb_dat_i[CTRL_FORCE_TRIGGER_BIT];

  // ****************************************************************
  // comparators
  // ****************************************************************
  logic [2:0] addr_eq;
  logic [2:0] addr_ge;
  logic [2:0] addr_le;
  logic [2:0] qual_ok;
  generate
    for (genvar i = 0; i < 3; i++) begin : g_cmp
      logic [AW-1:0] obs;
      logic dir_ok;
      logic dat_ok;
      logic valid;
      assign obs = cmp_ctl_ff[i][CMP_OPCODE_MATCH_SELECT_BIT] ? exec_addr : data_addr;
      assign valid = cmp_ctl_ff[i][CMP_OPCODE_MATCH_SELECT_BIT] ? exec_valid : data_valid;
      assign dir_ok = !cmp_ctl_ff[i][CMP_RWE_BIT] || (cmp_ctl_ff[i][CMP_RW_BIT] == data_read);
      if (i == 0) begin : g_dat
        assign dat_ok = ((data_bus ^ a_data_ff) & a_mask_ff) == '0;
      end else begin : g_nodat
        assign dat_ok = 1'h1;
      end
      assign addr_eq[i] = obs == cmp_addr_ff[i];
      assign addr_ge[i] = obs >= cmp_addr_ff[i];
      assign addr_le[i] = obs <= cmp_addr_ff[i];
      assign qual_ok[i] = cmp_ctl_ff[i][CMP_EN_BIT] && valid
        && (cmp_ctl_ff[i][CMP_OPCODE_MATCH_SELECT_BIT] || (dir_ok && dat_ok));
      assign match[i] = addr_eq[i] && qual_ok[i];
    end
  endgenerate

  // ****************************************************************
  // range and match mapping
  // ****************************************************************
  // range uses A as low bound and B as high bound, qualified by A
  logic rng_in;
  logic rng_out;
  logic rng_hit;
  assign rng_in = addr_ge[0] && (cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] ? exec_addr : data_addr)
    <= cmp_addr_ff[1];
  assign rng_out = !addr_ge[0] || (cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] ? exec_addr : data_addr)
    > cmp_addr_ff[1];
  assign rng_hit = qual_ok[0] && (range_ff[RANGE_OUT_BIT] ? rng_out : rng_in);
  always_comb begin
    match_vec = 4'h0;
    if (range_ff[1:0] != 2'h0) begin
      match_vec[0] = rng_hit;
      match_vec[3] = match[2];
    end else begin
      match_vec[0] = match[0];
      match_vec[1] = match[1];
      match_vec[3] = match[2];
    end
  end
  assign any_match = |match_vec;

  // ****************************************************************
  // state sequencer
  // ****************************************************************
  // trans_ff: per current state (1..3) and per source (m0,m1,m3,force)
  // a 2-bit target is looked up; target 0 means final state
  logic [1:0] src_idx;
  logic evt;
  always_comb begin
    src_idx = 2'h0;
    evt = 1'h1;
    if (ext_event || force_trigger_wr) begin
      src_idx = 2'h3;
    end else if (match_vec[0]) begin
      src_idx = 2'h0;
    end else if (match_vec[1]) begin
      src_idx = 2'h1;
    end else if (match_vec[3]) begin
      src_idx = 2'h2;
    end else begin
      evt = 1'h0;
    end
  end
  logic [1:0] tgt;
  assign tgt = trans_ff[{state_ff - 2'h1, src_idx, 1'h0} +: 2];
  assign brk_evt = arm_ff && evt && state_ff != DCS_ST0 && tgt == 2'h0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= DCS_ST0;
    end else if (!arm_ff || brk_evt) begin
      state_ff <= DCS_ST0;
    end else if (state_ff == DCS_ST0) begin
      state_ff <= DCS_ST1;
    end else if (evt) begin
      state_ff <= dcs_state_type'(tgt);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brk_ff <= 1'h0;
    end else begin
      brk_ff <= brk_evt;
    end
  end
  assign breakpoint = brk_ff;
  assign armed = arm_ff;

  // ****************************************************************
  // register writes
  // ****************************************************************
  // arm is cleared by the breakpoint, which wins over a set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm_ff <= 1'h0;
    end else if (brk_evt) begin
      arm_ff <= 1'h0;
    end else if (wr_hit && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
      arm_ff <= wb_dat_i[CTRL_ARM_BIT];
    end
  end
  // config writes only while disarmed, so the compare is stable while armed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < 3; k++) begin
        cmp_ctl_ff[k] <= 4'h0;
        cmp_addr_ff[k] <= '0;
      end
      a_data_ff <= RST_ZERO;
      a_mask_ff <= RST_MASK;
      range_ff <= 3'h0;
      trans_ff <= 24'h00_0000;
    end else if (wr_hit && !arm_ff) begin
      unique case (wb_adr_i)
        CMPA_CTL_OFS: cmp_ctl_ff[0] <= wb_dat_i[3:0];
        CMPB_CTL_OFS: cmp_ctl_ff[1] <= wb_dat_i[3:0];
        CMPD_CTL_OFS: cmp_ctl_ff[2] <= wb_dat_i[3:0];
        CMPA_ADDR_OFS: cmp_addr_ff[0] <= wb_dat_i[AW-1:0];
        CMPB_ADDR_HIGH_OFS: cmp_addr_ff[1][23:16] <= wb_dat_i[7:0];
        CMPB_ADDR_MID_OFS: cmp_addr_ff[1][15:8] <= wb_dat_i[7:0];
        CMPB_ADDR_LOW_OFS: cmp_addr_ff[1][7:0] <= wb_dat_i[7:0];
        CMPD_ADDR_OFS: cmp_addr_ff[2] <= wb_dat_i[AW-1:0];
        CMPA_DATA_OFS: a_data_ff <= wb_dat_i;
        CMPA_MASK_OFS: a_mask_ff <= wb_dat_i;
        RANGE_OFS: range_ff <= wb_dat_i[2:0];
        TRANS_OFS: trans_ff <= wb_dat_i[23:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_set = {arm_ff && any_match, brk_evt};
  assign irq_clr = (wr_hit && wb_adr_i == IRQ_CLR_OFS) ? wb_dat_i[IRQ_W-1:0] : '0;
  // set wins over clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_ff <= '0;
    end else if (wr_hit && wb_adr_i == IRQ_EN_OFS) begin
      irq_en_ff <= wb_dat_i[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ****************************************************************
  // wishbone read and ack
  // ****************************************************************
  // one wait state: ack in cycle after request, dropped after one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      rdata_ff <= 32'h0000_0000;
      unique case (wb_adr_i)
        CTRL_OFS: rdata_ff[CTRL_ARM_BIT] <= arm_ff;
        CMPA_CTL_OFS: rdata_ff[3:0] <= cmp_ctl_ff[0];
        CMPB_CTL_OFS: rdata_ff[3:0] <= cmp_ctl_ff[1];
        CMPD_CTL_OFS: rdata_ff[3:0] <= cmp_ctl_ff[2];
        CMPA_ADDR_OFS: rdata_ff[AW-1:0] <= cmp_addr_ff[0];
        CMPB_ADDR_HIGH_OFS: rdata_ff[7:0] <= cmp_addr_ff[1][23:16];
        CMPB_ADDR_MID_OFS: rdata_ff[7:0] <= cmp_addr_ff[1][15:8];
        CMPB_ADDR_LOW_OFS: rdata_ff[7:0] <= cmp_addr_ff[1][7:0];
        CMPD_ADDR_OFS: rdata_ff[AW-1:0] <= cmp_addr_ff[2];
        CMPA_DATA_OFS: rdata_ff <= a_data_ff;
        CMPA_MASK_OFS: rdata_ff <= a_mask_ff;
        RANGE_OFS: rdata_ff[2:0] <= range_ff;
        TRANS_OFS: rdata_ff[23:0] <= trans_ff;
        STATUS_OFS: rdata_ff[5:0] <= {match_vec[3], match_vec[1:0], arm_ff, state_ff};
        IRQ_STAT_OFS: rdata_ff[IRQ_W-1:0] <= irq_stat_ff;
        IRQ_EN_OFS: rdata_ff[IRQ_W-1:0] <= irq_en_ff;
        default: ;
      endcase
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  b_addr_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(arm_ff) && arm_ff |-> $stable(cmp_addr_ff[1]))
    else $error("comparator B address changed while armed");
  brk_disarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    brk_evt |=> !arm_ff && state_ff == DCS_ST0 && breakpoint)
    else $error("breakpoint did not disarm and reset state");
  idle_no_brk_a: assert property (@(posedge clk) disable iff (!rst_n)
    !arm_ff |=> !breakpoint)
    else $error("breakpoint while disarmed");
  inside_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    range_ff[1:0] != 2'h0 && !range_ff[RANGE_OUT_BIT] && qual_ok[0]
    && !cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] && data_addr >= cmp_addr_ff[0]
    && data_addr <= cmp_addr_ff[1] |-> match_vec[0])
    else $error("inside range missed");
  outside_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    range_ff[1:0] != 2'h0 && range_ff[RANGE_OUT_BIT] && match_vec[0]
    && !cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] |->
    data_addr < cmp_addr_ff[0] || data_addr > cmp_addr_ff[1])
    else $error("outside range false match");
  dir_qual_a: assert property (@(posedge clk) disable iff (!rst_n)
    match[1] && !cmp_ctl_ff[1][CMP_OPCODE_MATCH_SELECT_BIT] && cmp_ctl_ff[1][CMP_RWE_BIT]
    |-> data_read == cmp_ctl_ff[1][CMP_RW_BIT])
    else $error("direction qualification broken");
  data_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    match[0] && !cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] |->
    ((data_bus ^ a_data_ff) & a_mask_ff) == '0)
    else $error("data mask compare broken");
  force_move_a: assert property (@(posedge clk) disable iff (!rst_n)
    arm_ff && state_ff != DCS_ST0 && ext_event && tgt != 2'h0
    |=> state_ff == $past(tgt))
    else $error("forced transition missed");
  opcode_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    match[2] && cmp_ctl_ff[2][CMP_OPCODE_MATCH_SELECT_BIT] |-> exec_valid && exec_addr == cmp_addr_ff[2])
    else $error("opcode match without exec stage");

  // sequencer, mapping and comparator checks
  // disarmed holds state zero
  arm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !arm_ff |=> state_ff == DCS_ST0 && !breakpoint)
    else $error("disarmed sequencer left state zero");
  arm_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    arm_ff && state_ff == DCS_ST0 |=> state_ff == DCS_ST1)
    else $error("arming did not enter state one");
  seq_move_a: assert property (@(posedge clk) disable iff (!rst_n)
    arm_ff && state_ff != DCS_ST0 && evt && tgt != 2'h0
    |=> state_ff == $past(tgt))
    else $error("configured transition missed");
  brk_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    breakpoint |-> irq_stat_ff[IRQ_BRK_BIT])
    else $error("breakpoint not recorded in status");
  range_b_free_a: assert property (@(posedge clk) disable iff (!rst_n)
    range_ff[1:0] != 2'h0 |-> !match_vec[1])
    else $error("match one raised in range mode");
  b_bitwise_a: assert property (@(posedge clk) disable iff (!rst_n)
    match[1] && !cmp_ctl_ff[1][CMP_OPCODE_MATCH_SELECT_BIT] |-> data_valid && data_addr == cmp_addr_ff[1])
    else $error("comparator B matched a different address");
  d_addr_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_ctl_ff[2][CMP_EN_BIT] && !cmp_ctl_ff[2][CMP_OPCODE_MATCH_SELECT_BIT] && !cmp_ctl_ff[2][CMP_RWE_BIT]
    && data_valid && data_addr == cmp_addr_ff[2] |-> match[2])
    else $error("comparator D depends on data");
  access_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    match[0] && !cmp_ctl_ff[0][CMP_OPCODE_MATCH_SELECT_BIT] |-> data_valid && data_addr == cmp_addr_ff[0])
    else $error("comparator A matched a different address");
  opcode_any_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_ctl_ff[1][CMP_EN_BIT] && cmp_ctl_ff[1][CMP_OPCODE_MATCH_SELECT_BIT] && exec_valid
    && exec_addr == cmp_addr_ff[1] |-> match[1])
    else $error("opcode match depends on direction");
endmodule : dcs_top
`default_nettype wire

// ==== hw/dcs_pkg.sv ====
package dcs_pkg;
  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMPA_CTL_OFS = 8'h04;
  localparam logic [7:0] CMPB_CTL_OFS = 8'h08;
  localparam logic [7:0] CMPD_CTL_OFS = 8'h0c;
  localparam logic [7:0] CMPA_ADDR_OFS = 8'h10;
  localparam logic [7:0] CMPB_ADDR_HIGH_OFS = 8'h14;
  localparam logic [7:0] CMPB_ADDR_MID_OFS = 8'h18;
  localparam logic [7:0] CMPB_ADDR_LOW_OFS = 8'h1c;
  localparam logic [7:0] CMPD_ADDR_OFS = 8'h20;
  localparam logic [7:0] CMPA_DATA_OFS = 8'h24;
  localparam logic [7:0] CMPA_MASK_OFS = 8'h28;
  localparam logic [7:0] RANGE_OFS = 8'h2c;
  localparam logic [7:0] TRANS_OFS = 8'h30;
  localparam logic [7:0] STATUS_OFS = 8'h34;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h38;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h3c;
  localparam logic [7:0] IRQ_EN_OFS = 8'h40;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_FORCE_TRIGGER_BIT = 1;
  localparam int CMP_EN_BIT = 0;
  localparam int CMP_OPCODE_MATCH_SELECT_BIT = 1;
  localparam int CMP_RWE_BIT = 2;
  localparam int CMP_RW_BIT = 3;
  localparam int RANGE_OUT_BIT = 2;
  localparam int IRQ_BRK_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int IRQ_W = 2;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'hffff_ffff;
  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    DCS_ST0,
    DCS_ST1,
    DCS_ST2,
    DCS_ST3
  } dcs_state_type;
endpackage : dcs_pkg

// ==== tb/dcs_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// processor bus model
// ********
module dcs_cpu_model (
  input wire logic clk,
  output logic [23:0] data_addr,
  output logic [31:0] data_bus,
  output logic data_valid,
  output logic data_read,
  output logic [23:0] exec_addr,
  output logic exec_valid,
  output logic ext_event
);
  // idle buses start quiet
  initial begin
    data_addr = 24'h00_0000;
    data_bus = 32'h0000_0000;
    data_valid = 1'h0;
    data_read = 1'h0;
    exec_addr = 24'h00_0000;
    exec_valid = 1'h0;
    ext_event = 1'h0;
  end
  // one access; afterwards lines invert so stale values never match
  task automatic access(input logic [23:0] a, input logic [31:0] d, input logic rd);
    @(posedge clk);
    data_addr <= a;
    data_bus <= d;
    data_read <= rd;
    data_valid <= 1'h1;
    @(posedge clk);
    data_addr <= ~a;
    data_bus <= ~d;
    data_read <= ~rd;
    data_valid <= 1'h0;
  endtask : access
  task automatic opcode(input logic [23:0] a);
    @(posedge clk);
    exec_addr <= a;
    exec_valid <= 1'h1;
    @(posedge clk);
    exec_addr <= ~a;
    exec_valid <= 1'h0;
  endtask : opcode
  task automatic pulse();
    @(posedge clk);
    ext_event <= 1'h1;
    @(posedge clk);
    ext_event <= 1'h0;
  endtask : pulse
endmodule : dcs_cpu_model
`default_nettype wire

// ==== tb/debug_comparator_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// bench top
// ********
module debug_comparator_sequencer_tb;
  import dcs_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dout, rdat;
  logic ack, bp, armed, irq, dval, drd, eval, ev, got;
  logic [23:0] daddr, eaddr;
  logic [31:0] dbus;
  logic [23:0] rng [4] = '{24'h00_00ff, 24'h00_0100, 24'h00_0200, 24'h00_0201};
  int miscompares = 0;
  int checked = 0;
  // free-running clock
  always #20 clk = ~clk;
  dcs_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .data_addr(daddr), .data_bus(dbus), .data_valid(dval), .data_read(drd),
    .exec_addr(eaddr), .exec_valid(eval), .ext_event(ev), .breakpoint(bp),
    .armed(armed), .irq(irq));
  dcs_cpu_model cpu_u (.clk(clk), .data_addr(daddr), .data_bus(dbus), .data_valid(dval),
    .data_read(drd), .exec_addr(eaddr), .exec_valid(eval), .ext_event(ev));
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // single classic cycle; request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (ack === 1'h1) break;
    end
    if (i == 16) begin
      check("ack", {31'h0, ack}, 32'h0000_0001);
      wrap_up();
    end
    rdat = dout;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0000_0000);
    check(name, rdat, exp);
  endtask : rd_chk
  // breakpoint is a one-cycle pulse, so look at every cycle of a short window
  task automatic wait_bp(output logic seen);
    seen = 1'h0;
    for (int i = 0; i < 8; i++) begin
      #1;
      if (bp === 1'h1) seen = 1'h1;
      @(posedge clk);
    end
  endtask : wait_bp
  // arm, one bus event, judge breakpoint, disarm
  task automatic trial(input logic [23:0] a, input logic [31:0] d, input logic r,
    input logic op, input logic exp);
    logic s;
    wr(CTRL_OFS, 32'h0000_0001);
    if (op) cpu_u.opcode(a);
    else cpu_u.access(a, d, r);
    wait_bp(s);
    check("breakpoint", {31'h0, s}, {31'h0, exp});
    if (exp) check("armed", {31'h0, armed}, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0000);
  endtask : trial
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk("mask", CMPA_MASK_OFS, RST_MASK);
    rd_chk("status", STATUS_OFS, RST_ZERO);
    rd_chk("unmapped", 8'h44, RST_ZERO);
    wr(CMPB_ADDR_HIGH_OFS, 32'h0000_0012);
    wr(CMPB_ADDR_MID_OFS, 32'h0000_0034);
    wr(CMPB_ADDR_LOW_OFS, 32'h0000_0056);
    wr(CMPB_CTL_OFS, 32'h0000_0001);
    wr(CMPA_MASK_OFS, 32'h0000_0000);
    trial(24'h12_3457, 32'h0000_0000, 1'h1, 1'h0, 1'h0);
    trial(24'h92_3456, 32'h0000_0000, 1'h1, 1'h0, 1'h0);
    cpu_u.access(24'h12_3456, 32'h0000_0000, 1'h1);
    wait_bp(got);
    check("disarmed", {31'h0, got}, 32'h0000_0000);
    trial(24'h12_3456, 32'h0000_0000, 1'h1, 1'h0, 1'h1);
    #1;
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    rd_chk("irq status", IRQ_STAT_OFS, 32'h0000_0003);
    wr(IRQ_EN_OFS, 32'h0000_0001);
    #1;
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    wr(IRQ_CLR_OFS, 32'h0000_0003);
    #1;
    check("irq off", {31'h0, irq}, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0001);
    wr(CMPB_ADDR_HIGH_OFS, 32'h0000_0077);
    rd_chk("b high", CMPB_ADDR_HIGH_OFS, 32'h0000_0012);
    wr(CTRL_OFS, 32'h0000_0000);
    // direction select against bus direction
    for (int i = 0; i < 4; i++) begin
      wr(CMPB_CTL_OFS, 32'h0000_0005 | (i[0] << 3));
      trial(24'h12_3456, 32'h0000_0000, i[1], 1'h0, i[0] == i[1]);
    end
    wr(CMPB_CTL_OFS, 32'h0000_000f);
    trial(24'h12_3456, 32'h0000_0000, 1'h0, 1'h1, 1'h1);
    trial(24'h12_3456, 32'h0000_0000, 1'h1, 1'h0, 1'h0);
    wr(CMPB_CTL_OFS, 32'h0000_0001);
    trial(24'h12_3456, 32'h0000_0000, 1'h0, 1'h0, 1'h1);
    // walk 1 -> 2 -> 3 -> 1 -> 2, event back to 1, then event to final
    wr(TRANS_OFS, 32'h0004_4c08);
    wr(CTRL_OFS, 32'h0000_0001);
    cpu_u.access(24'h12_3456, 32'h0000_0000, 1'h0);
    rd_chk("state two", STATUS_OFS, 32'h0000_0006);
    cpu_u.access(24'h12_3456, 32'h0000_0000, 1'h0);
    rd_chk("state three", STATUS_OFS, 32'h0000_0007);
    cpu_u.access(24'h12_3456, 32'h0000_0000, 1'h0);
    rd_chk("state one", STATUS_OFS, 32'h0000_0005);
    cpu_u.access(24'h12_3456, 32'h0000_0000, 1'h0);
    cpu_u.pulse();
    rd_chk("event move", STATUS_OFS, 32'h0000_0005);
    cpu_u.pulse();
    wait_bp(got);
    check("event", {31'h0, got}, 32'h0000_0001);
    rd_chk("final", STATUS_OFS, RST_ZERO);
    // a forcing write breaks inside its own bus cycle, so judge it by the sticky bit
    wr(IRQ_CLR_OFS, 32'h0000_0003);
    wr(CTRL_OFS, 32'h0000_0001);
    wr(CTRL_OFS, 32'h0000_0003);
    rd_chk("force", IRQ_STAT_OFS, 32'h0000_0001);
    check("force disarm", {31'h0, armed}, 32'h0000_0000);
    // address ranges bounded by A low and B high
    wr(TRANS_OFS, 32'h0000_0000);
    wr(CMPA_CTL_OFS, 32'h0000_0001);
    wr(CMPA_ADDR_OFS, 32'h0000_0100);
    wr(CMPB_ADDR_HIGH_OFS, 32'h0000_0000);
    wr(CMPB_ADDR_MID_OFS, 32'h0000_0002);
    wr(CMPB_ADDR_LOW_OFS, 32'h0000_0000);
    wr(RANGE_OFS, 32'h0000_0001);
    for (int i = 0; i < 4; i++) trial(rng[i], 32'h0, 1'h1, 1'h0, i == 1 || i == 2);
    wr(RANGE_OFS, 32'h0000_0005);
    for (int i = 0; i < 4; i++) trial(rng[i], 32'h0, 1'h1, 1'h0, i == 0 || i == 3);
    // masked data compare on A
    wr(RANGE_OFS, 32'h0000_0000);
    wr(CMPB_CTL_OFS, 32'h0000_0000);
    wr(CMPA_DATA_OFS, 32'h0000_0055);
    wr(CMPA_MASK_OFS, 32'h0000_00ff);
    trial(24'h00_0100, 32'haabb_cc55, 1'h0, 1'h0, 1'h1);
    trial(24'h00_0100, 32'haabb_cc56, 1'h0, 1'h0, 1'h0);
    // comparator D on opcode, then on a data access whatever the data
    wr(CMPA_CTL_OFS, 32'h0000_0000);
    wr(CMPD_ADDR_OFS, 32'h0000_0abc);
    wr(CMPD_CTL_OFS, 32'h0000_0003);
    trial(24'h00_0abc, 32'h0000_0000, 1'h0, 1'h1, 1'h1);
    wr(CMPD_CTL_OFS, 32'h0000_0001);
    trial(24'h00_0abc, 32'h1234_5678, 1'h1, 1'h0, 1'h1);
    wrap_up();
  end
endmodule : debug_comparator_sequencer_tb
`default_nettype wire
